// >>> core/rrt_pkg.sv
// Package: constants, register map and frame descriptors of the ring redundancy block
package rrt_pkg;

  // System clock and the two timer rates, all in MHz
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TS_MHZ = 100;
  localparam int unsigned DT_MHZ = 50;

  // Phase accumulator constants derived from the rates above
  localparam logic [7:0] ACC_MODULUS = 8'(CLK_MHZ);
  localparam logic [7:0] TS_STEP = 8'(TS_MHZ);
  localparam logic [7:0] DT_STEP = 8'(DT_MHZ);
  localparam logic [7:0] ACC_RESET = 8'h00;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_TS_LOW = 8'h64;
  localparam logic [7:0] IDX_TS_HIGH = 8'h66;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h68;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h6A;
  localparam logic [7:0] IDX_CONTROL = 8'h6C;

  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_TS_LOW = {2'h0, IDX_TS_LOW, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TS_HIGH = {2'h0, IDX_TS_HIGH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_LOW = {2'h0, IDX_RELOAD_LOW, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_HIGH = {2'h0, IDX_RELOAD_HIGH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};

  // Control register field positions
  localparam int unsigned CTL_RING_EN = 1;
  localparam int unsigned CTL_SUPERVISOR = 2;
  localparam int unsigned CTL_P1_RX_BLOCKED = 3;
  localparam int unsigned CTL_P1_TX_BLOCKED = 4;
  localparam int unsigned CTL_P2_RX_BLOCKED = 5;
  localparam int unsigned CTL_P2_TX_BLOCKED = 6;
  localparam int unsigned CTL_P1_BEACON_TO_HOST = 7;
  localparam int unsigned CTL_P2_BEACON_TO_HOST = 8;
  localparam int unsigned CTL_P1_BTO_ENABLE = 9;
  localparam int unsigned CTL_P2_BTO_ENABLE = 10;
  localparam int unsigned CTL_PIT_ENABLE = 11;
  localparam int unsigned CTL_CLR_SRCID = 12;
  localparam int unsigned CTL_DROP_RESERVED = 13;
  localparam int unsigned CTL_ANNOUNCE_TO_HOST = 14;

  // Storable control bits: 14:1 except the self-clearing one
  localparam logic [15:0] CTL_STORE_MASK = 16'h6FFE;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [31:0] REG32_RESET = 32'h00000000;
  localparam logic [31:0] CNT_ONE = 32'h00000001;

  // Port identifiers as carried in a host frame's source port field
  localparam logic [1:0] PORT1_ID = 2'h1;
  localparam logic [1:0] PORT2_ID = 2'h2;

  // Ring frame classes, as recognised by the parser in front of this block
  typedef enum logic [2:0] {
    FRM_OTHER,
    FRM_BEACON,
    FRM_NBR_CHECK,
    FRM_LINK_STATUS,
    FRM_ANNOUNCE
  } rrt_frame_kind_t;

  // Descriptor of a frame received on an external port
  typedef struct packed {
    rrt_frame_kind_t kind;
    logic src_is_supervisor;
    logic dst_is_host;
    logic dst_reserved;
    logic crc_ok;
    logic host_wanted;
    logic other_wanted;
  } rrt_rx_frame_t;

  // Forwarding verdict for one received frame
  typedef struct packed {
    logic to_host;
    logic to_other;
  } rrt_fwd_t;

  // Descriptor of a frame the host wants to send
  typedef struct packed {
    rrt_frame_kind_t kind;
    logic [1:0] src_port;
  } rrt_host_tx_t;

endpackage

// >>> core/rrt_down_timer.sv
// Reloading 32-bit down-counter shared by the interval and beacon timeout timers
`timescale 1ns/1ns
module rrt_down_timer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic [31:0] reload_i,
  // Status
  output logic expire_o,
  output logic [31:0] count_o
);
  import rrt_pkg::*;

  logic armed_r;
  logic expire_r;
  logic [31:0] count_r;

  // Arm on the enable edge by loading the reload value
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= enable_i;
    end
  end

  // Count on each slow tick; a disabled timer freezes where it stands
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= REG32_RESET;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (enable_i && !armed_r) begin
        count_r <= reload_i;
      end else if (enable_i && restart_i) begin
        count_r <= reload_i;
      end else if (enable_i && tick_i) begin
        // A reload of zero or one expires on every tick
        if (count_r <= CNT_ONE) begin
          count_r <= reload_i;
          expire_r <= 1'b1;
        end else begin
          count_r <= count_r - CNT_ONE;
        end
      end
    end
  end

  assign expire_o = expire_r;
  assign count_o = count_r;

endmodule

// >>> core/rrt_ring_ctrl.sv
// Ring redundancy timers, control register and forwarding verdicts
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module rrt_ring_ctrl (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic [rrt_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Received frame descriptors, index 0 is port 1
  input wire logic [1:0] rx_valid_i,
  input wire rrt_pkg::rrt_rx_frame_t [1:0] rx_frame_i,
  output logic [1:0] fwd_valid_o,
  output logic [1:0] fwd_to_host_o,
  output logic [1:0] fwd_to_other_o,
  // Host transmit descriptor
  input wire logic host_tx_valid_i,
  input wire rrt_pkg::rrt_host_tx_t host_tx_i,
  output logic host_tx_done_o,
  output logic [1:0] host_tx_permit_o,
  // Beacon timeout timers
  input wire logic [31:0] beacon_timeout_i,
  output logic [1:0] beacon_timeout_o,
  // Event flag and interrupt
  input wire logic pit_mask_i,
  input wire logic pit_clear_i,
  output logic pit_flag_o,
  output logic host_irq_o,
  // Other status towards the switch
  output logic srcid_clear_o,
  output logic [31:0] timestamp_o
);
  import rrt_pkg::*;

  // One step of a fractional rate divider: {tick, next phase}
  function automatic logic [8:0] rate_step(input logic [7:0] acc, input logic [7:0] step);
    logic [8:0] sum;
    sum = {1'b0, acc} + {1'b0, step};
    if (sum >= {1'b0, ACC_MODULUS}) begin
      rate_step = {1'b1, 8'(sum - {1'b0, ACC_MODULUS})};
    end else begin
      rate_step = {1'b0, sum[7:0]};
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    lane_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic [7:0] ts_acc_r;
  logic [7:0] dt_acc_r;
  logic ts_tick_r;
  logic dt_tick_r;
  logic [8:0] ts_step;
  logic [8:0] dt_step;
  logic [31:0] ts_count_r;
  logic [15:0] ts_high_hold_r;
  logic [15:0] reload_low_r;
  logic [15:0] reload_high_r;
  logic [15:0] control_r;
  logic srcid_clear_r;
  logic pit_flag_r;
  logic pit_expire;
  logic [31:0] prdata_r;
  logic setup_rd;
  logic access_wr;
  logic mapped;
  logic ring_en;
  logic supervisor;
  logic [1:0] rx_blocked;
  logic [1:0] tx_blocked;
  logic [1:0] beacon_to_host;
  logic [1:0] bto_enable;
  logic [1:0] beacon_seen;
  rrt_fwd_t [1:0] verdict;
  rrt_fwd_t [1:0] verdict_r;
  logic [1:0] fwd_valid_r;
  logic [1:0] tx_permit;
  logic [1:0] tx_permit_r;
  logic tx_done_r;

  // Control fields
  assign ring_en = control_r[CTL_RING_EN];
  assign supervisor = control_r[CTL_SUPERVISOR];
  assign rx_blocked = {control_r[CTL_P2_RX_BLOCKED], control_r[CTL_P1_RX_BLOCKED]};
  assign tx_blocked = {control_r[CTL_P2_TX_BLOCKED], control_r[CTL_P1_TX_BLOCKED]};
  assign beacon_to_host = {control_r[CTL_P2_BEACON_TO_HOST], control_r[CTL_P1_BEACON_TO_HOST]};
  assign bto_enable = {control_r[CTL_P2_BTO_ENABLE], control_r[CTL_P1_BTO_ENABLE]};

  // Slow rate enables; phase accumulators give exact average rates
  assign ts_step = rate_step(ts_acc_r, TS_STEP);
  assign dt_step = rate_step(dt_acc_r, DT_STEP);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_acc_r <= ACC_RESET;
      dt_acc_r <= ACC_RESET;
      ts_tick_r <= 1'b0;
      dt_tick_r <= 1'b0;
    end else begin
      ts_acc_r <= ts_step[7:0];
      dt_acc_r <= dt_step[7:0];
      ts_tick_r <= ts_step[8];
      dt_tick_r <= dt_step[8];
    end
  end

  // Free-running timestamp; never stopped, wraps by width
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_count_r <= REG32_RESET;
    end else if (ts_tick_r) begin
      ts_count_r <= ts_count_r + CNT_ONE;
    end
  end

  // APB phase decode; every access completes without wait states
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign access_wr = psel_i && penable_i && pwrite_i;
  assign mapped = (paddr_i == ADDR_TS_LOW) || (paddr_i == ADDR_TS_HIGH) ||
                  (paddr_i == ADDR_RELOAD_LOW) || (paddr_i == ADDR_RELOAD_HIGH) ||
                  (paddr_i == ADDR_CONTROL);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // High-half holder; captured with the same edge as the low-half data
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_high_hold_r <= REG16_RESET;
    end else if (setup_rd && (paddr_i == ADDR_TS_LOW)) begin
      ts_high_hold_r <= ts_count_r[31:16];
    end
  end

  // Read data taken in the setup cycle so that it is a flop in access
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_r <= REG32_RESET;
    end else if (setup_rd) begin
      case (paddr_i)
        ADDR_TS_LOW: begin
          prdata_r <= {REG16_RESET, ts_count_r[15:0]};
        end
        ADDR_TS_HIGH: begin
          prdata_r <= {REG16_RESET, ts_high_hold_r};
        end
        ADDR_RELOAD_LOW: begin
          prdata_r <= {REG16_RESET, reload_low_r};
        end
        ADDR_RELOAD_HIGH: begin
          prdata_r <= {REG16_RESET, reload_high_r};
        end
        ADDR_CONTROL: begin
          prdata_r <= {REG16_RESET, control_r};
        end
        default: begin
          prdata_r <= REG32_RESET;
        end
      endcase
    end
  end
  assign prdata_o = prdata_r;

  // Interval reload value; changing it while enabled takes effect at next reload
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reload_low_r <= REG16_RESET;
      reload_high_r <= REG16_RESET;
    end else if (access_wr) begin
      if (paddr_i == ADDR_RELOAD_LOW) begin
        reload_low_r <= lane_merge(reload_low_r, pwdata_i, pstrb_i);
      end
      if (paddr_i == ADDR_RELOAD_HIGH) begin
        reload_high_r <= lane_merge(reload_high_r, pwdata_i, pstrb_i);
      end
    end
  end

  // Control register; reserved and self-clearing bits never store
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      control_r <= REG16_RESET;
    end else if (access_wr && (paddr_i == ADDR_CONTROL)) begin
      control_r <= lane_merge(control_r, pwdata_i, pstrb_i) & CTL_STORE_MASK;
    end
  end

  // Clear-source-ID strobe, one cycle after the write completes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      srcid_clear_r <= 1'b0;
    end else begin
      srcid_clear_r <= access_wr && (paddr_i == ADDR_CONTROL) && pstrb_i[1] &&
                       pwdata_i[CTL_CLR_SRCID];
    end
  end
  assign srcid_clear_o = srcid_clear_r;

  // Periodic interval timer
  rrt_down_timer u_pit (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .enable_i(control_r[CTL_PIT_ENABLE]),
    .tick_i(dt_tick_r),
    .restart_i(1'b0),
    .reload_i({reload_high_r, reload_low_r}),
    .expire_o(pit_expire),
    .count_o()
  );

  // Interval event flag; a new expiry beats a clear in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pit_flag_r <= 1'b0;
    end else if (pit_expire) begin
      pit_flag_r <= 1'b1;
    end else if (pit_clear_i) begin
      pit_flag_r <= 1'b0;
    end
  end
  assign pit_flag_o = pit_flag_r;
  assign host_irq_o = pit_flag_r && pit_mask_i;

  // Supervisor beacons with good CRC restart that port's timeout
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      beacon_seen[p] = rx_valid_i[p] && (rx_frame_i[p].kind == FRM_BEACON) &&
                       rx_frame_i[p].src_is_supervisor && rx_frame_i[p].crc_ok;
    end
  end

  // Per-port beacon timeout timers from one shared value
  for (genvar g = 0; g < 2; g++) begin : g_bto
    rrt_down_timer u_bto (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .enable_i(ring_en && bto_enable[g]),
      .tick_i(dt_tick_r),
      .restart_i(beacon_seen[g]),
      .reload_i(beacon_timeout_i),
      .expire_o(beacon_timeout_o[g]),
      .count_o()
    );
  end

  // Forwarding verdict per received frame; other index is the opposite port
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      verdict[p].to_host = rx_frame_i[p].host_wanted;
      verdict[p].to_other = rx_frame_i[p].other_wanted;
      if (ring_en) begin
        case (rx_frame_i[p].kind)
          FRM_BEACON: begin
            // Foreign-source beacons always reach the host
            verdict[p].to_host = beacon_to_host[p] ||
                                 !rx_frame_i[p].src_is_supervisor;
            verdict[p].to_other = !supervisor;
          end
          FRM_NBR_CHECK: begin
            verdict[p].to_host = 1'b1;
            verdict[p].to_other = 1'b0;
          end
          FRM_LINK_STATUS: begin
            verdict[p].to_host = rx_frame_i[p].dst_is_host;
            verdict[p].to_other = !rx_frame_i[p].dst_is_host && !rx_blocked[p];
          end
          FRM_ANNOUNCE: begin
            verdict[p].to_host = control_r[CTL_ANNOUNCE_TO_HOST];
            verdict[p].to_other = rx_frame_i[p].other_wanted && !rx_blocked[p];
          end
          default: begin
            verdict[p].to_host = rx_frame_i[p].host_wanted && !rx_blocked[p];
            verdict[p].to_other = rx_frame_i[p].other_wanted && !rx_blocked[p];
          end
        endcase
        // Opposite port transmit block passes only relayed beacons of a non-supervisor
        if (tx_blocked[1-p] && !((rx_frame_i[p].kind == FRM_BEACON) && !supervisor)) begin
          verdict[p].to_other = 1'b0;
        end
      end
      if (control_r[CTL_DROP_RESERVED] && rx_frame_i[p].dst_reserved) begin
        verdict[p].to_other = 1'b0;
      end
    end
  end

  // Verdicts registered; one cycle after the descriptor
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_valid_r <= 2'h0;
      verdict_r <= '0;
    end else begin
      fwd_valid_r <= rx_valid_i;
      for (int p = 0; p < 2; p++) begin
        if (rx_valid_i[p]) begin
          verdict_r[p] <= verdict[p];
        end
      end
    end
  end

  assign fwd_valid_o = fwd_valid_r;
  assign fwd_to_host_o = {verdict_r[1].to_host, verdict_r[0].to_host};
  assign fwd_to_other_o = {verdict_r[1].to_other, verdict_r[0].to_other};

  // Host transmit permission per external port
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      tx_permit[p] = 1'b1;
      if (ring_en && tx_blocked[p]) begin
        tx_permit[p] = ((host_tx_i.kind == FRM_BEACON) && supervisor) ||
                       ((host_tx_i.kind == FRM_NBR_CHECK) &&
                        (host_tx_i.src_port == ((p == 0) ? PORT1_ID : PORT2_ID)));
      end
    end
  end

  // Permission registered with a done strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_done_r <= 1'b0;
      tx_permit_r <= 2'h0;
    end else begin
      tx_done_r <= host_tx_valid_i;
      if (host_tx_valid_i) begin
        tx_permit_r <= tx_permit;
      end
    end
  end

  assign host_tx_done_o = tx_done_r;
  assign host_tx_permit_o = tx_permit_r;
  assign timestamp_o = ts_count_r;

endmodule

// >>> sim/rrt_ring_ctrl_sva.sv
// Port-level checker of the ring redundancy timers and control block
`timescale 1ns/1ns
module rrt_ring_ctrl_sva
  import rrt_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // APB
  input wire logic [rrt_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Frames and host transmit
  input wire logic [1:0] rx_valid_i,
  input wire logic [1:0] fwd_valid_o,
  input wire logic [1:0] fwd_to_host_o,
  input wire logic host_tx_valid_i,
  input wire logic host_tx_done_o,
  // Timers and status
  input wire logic pit_mask_i,
  input wire logic pit_clear_i,
  input wire logic pit_flag_o,
  input wire logic host_irq_o,
  input wire logic srcid_clear_o,
  input wire logic [31:0] timestamp_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  logic acc;
  // Decode of the five mapped words
  assign mapped = paddr_i inside {ADDR_TS_LOW, ADDR_TS_HIGH, ADDR_RELOAD_LOW,
                                  ADDR_RELOAD_HIGH, ADDR_CONTROL};
  assign acc = psel_i && penable_i;
  a_unmapped_err: assert property (acc |-> pslverr_o == !mapped)
    else $error("error response disagrees with the address map");
  a_upper_zero: assert property (acc && !pwrite_i && mapped |-> prdata_o[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  a_fwd_follow: assert property (rx_valid_i[0] |=> fwd_valid_o[0])
    else $error("no verdict after a port 1 frame");
  a_fwd_quiet: assert property (!rx_valid_i[1] |=> !fwd_valid_o[1])
    else $error("port 2 verdict without a frame");
  a_tx_answer: assert property (host_tx_valid_i |=> host_tx_done_o)
    else $error("host transmit not answered");
  a_irq_gate: assert property (host_irq_o == (pit_flag_o && pit_mask_i))
    else $error("interrupt does not follow flag and mask");
  a_ts_step: assert property (1'b1 |=> (timestamp_o - $past(timestamp_o)) <= 32'h1)
    else $error("timestamp jumped");
  a_ts_moving: assert property ($stable(timestamp_o) [*5] |-> 1'b0)
    else $error("timestamp stalled");
  a_srcid_pulse: assert property (acc && pwrite_i && paddr_i == ADDR_CONTROL &&
    pwdata_i[CTL_CLR_SRCID] |=> srcid_clear_o ##1 !srcid_clear_o)
    else $error("source-ID clear not a single pulse");
  a_flag_sticky: assert property (pit_flag_o && !pit_clear_i |=> pit_flag_o)
    else $error("event flag dropped without clear");
  // Main scenarios reached
  c_host_fwd: cover property (fwd_valid_o[0] && fwd_to_host_o[0]);
  c_irq: cover property (host_irq_o);
  c_err: cover property (acc && pslverr_o);
endmodule

bind rrt_ring_ctrl rrt_ring_ctrl_sva i_rrt_ring_ctrl_sva (.mclk_i(mclk_i), .rst_i(rst_i),
  .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .rx_valid_i(rx_valid_i), .fwd_valid_o(fwd_valid_o), .fwd_to_host_o(fwd_to_host_o),
  .host_tx_valid_i(host_tx_valid_i), .host_tx_done_o(host_tx_done_o),
  .pit_mask_i(pit_mask_i), .pit_clear_i(pit_clear_i), .pit_flag_o(pit_flag_o),
  .host_irq_o(host_irq_o), .srcid_clear_o(srcid_clear_o), .timestamp_o(timestamp_o));

// >>> sim/rrt_ring_nbr.sv
// Ring neighbour model delivering received frame descriptors on both ports
`timescale 1ns/1ns
module rrt_ring_nbr
  import rrt_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Descriptors towards the block
  output logic [1:0] rx_valid_o,
  output rrt_pkg::rrt_rx_frame_t [1:0] rx_frame_o
);
  rrt_rx_frame_t held_r = '0;
  logic [8:0] noise_r = 9'h000;
  logic [1:0] busy_r = 2'h0;
  // Outside a frame the descriptor wanders, so a stale one never looks valid
  always @(posedge mclk_i) noise_r <= noise_r + 9'h0A7;
  assign rx_valid_o = busy_r;
  assign rx_frame_o[0] = busy_r[0] ? held_r : rrt_rx_frame_t'(noise_r);
  assign rx_frame_o[1] = busy_r[1] ? held_r : rrt_rx_frame_t'(~noise_r);
  // One frame: valid for exactly one cycle, changed just after an edge
  task automatic send(input int p, input rrt_rx_frame_t f);
    @(posedge mclk_i);
    held_r <= f;
    busy_r[p] <= 1'b1;
    @(posedge mclk_i);
    busy_r[p] <= 1'b0;
  endtask
endmodule

// >>> sim/test_rrt_ring_ctrl.sv
// Self-checking bench of the ring redundancy timers and control block
`timescale 1ns/1ns
module test_rrt_ring_ctrl;
  import rrt_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready, e;
  logic [31:0] pwdata = '0, prdata, q, w, ts0, ts1;
  logic [1:0] rx_valid, fwd_valid, fwd_host, fwd_other, htx_permit, bto;
  rrt_rx_frame_t [1:0] rx_frame;
  rrt_rx_frame_t f;
  rrt_host_tx_t htx = '0;
  logic htx_valid = 1'b0, htx_done, pit_mask = 1'b0, pit_clear = 1'b0, pit_flag, irq;
  logic srcid_clr;
  logic [31:0] ts, rl[3];
  logic [15:0] c;
  logic [3:0] x;
  int fail_count = 0, tests_run = 0, cyc = 0, seed, t0, t1, n;

  rrt_ring_ctrl i_rrt_ring_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rx_valid_i(rx_valid), .rx_frame_i(rx_frame), .fwd_valid_o(fwd_valid),
    .fwd_to_host_o(fwd_host), .fwd_to_other_o(fwd_other), .host_tx_valid_i(htx_valid),
    .host_tx_i(htx), .host_tx_done_o(htx_done), .host_tx_permit_o(htx_permit),
    .beacon_timeout_i(32'h00000008), .beacon_timeout_o(bto), .pit_mask_i(pit_mask),
    .pit_clear_i(pit_clear), .pit_flag_o(pit_flag), .host_irq_o(irq),
    .srcid_clear_o(srcid_clr), .timestamp_o(ts));
  rrt_ring_nbr i_rrt_ring_nbr (.mclk_i(mclk_i), .rx_valid_o(rx_valid), .rx_frame_o(rx_frame));

  // 250 MHz clock
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  // Cycle count; cuts a hang short
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Tolerant compare for counts whose sampling phase is not exact
  task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if ($isunknown(got) || (got - exp + 32'h2) > 32'h4) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer: setup, access held until pready is seen high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Coherent timestamp: low half first, high half from the held copy
  task automatic read_ts(output logic [31:0] v, output int t);
    apb(1'b0, ADDR_TS_LOW, 32'h0);
    t = cyc;
    v[15:0] = q[15:0];
    repeat (3) @(posedge mclk_i);
    apb(1'b0, ADDR_TS_HIGH, 32'h0);
    v[31:16] = q[15:0];
  endtask
  // Measures cycles between two event flags, clearing the first
  task automatic pit_period(output int m);
    m = 0;
    while (irq !== 1'b1 && m < 400) begin
      @(posedge mclk_i);
      m++;
    end
    pit_clear <= 1'b1;
    m = 0;
    do begin
      @(posedge mclk_i);
      pit_clear <= 1'b0;
      m++;
    end while ((irq !== 1'b1 || m < 2) && m < 400);
  endtask
  // Expected verdict {care host, care other, host, other}
  function automatic logic [3:0] exp_fwd(input logic [15:0] r, input int p,
                                         input rrt_rx_frame_t d);
    logic rb;
    logic br;
    rb = p ? r[CTL_P2_RX_BLOCKED] : r[CTL_P1_RX_BLOCKED];
    br = p ? r[CTL_P2_BEACON_TO_HOST] : r[CTL_P1_BEACON_TO_HOST];
    if (!r[CTL_RING_EN])
      return {2'b11, d.host_wanted, d.other_wanted & !(r[CTL_DROP_RESERVED] & d.dst_reserved)};
    // Announce frames reach the host per the announce-to-host bit, whatever the receive block says
    if (d.kind == FRM_ANNOUNCE)
      return {1'b1, rb, r[CTL_ANNOUNCE_TO_HOST], 1'b0};
    if (!rb)
      return (d.kind == FRM_BEACON) ? {2'b10, br | !d.src_is_supervisor, 1'b0} : 4'h0;
    case (d.kind)
      FRM_BEACON: return {2'b11, br | !d.src_is_supervisor, !r[CTL_SUPERVISOR]};
      FRM_NBR_CHECK: return 4'hE;
      FRM_LINK_STATUS: return {2'b11, d.dst_is_host, 1'b0};
      default: return 4'hC;
    endcase
  endfunction
  // Expected transmit permission per port, bit 0 is port 1
  function automatic logic [1:0] exp_tx(input logic [15:0] r, input rrt_host_tx_t t);
    logic nc;
    nc = t.kind == FRM_NBR_CHECK;
    if (!r[CTL_RING_EN]) return 2'b11;
    return ~{r[CTL_P2_TX_BLOCKED], r[CTL_P1_TX_BLOCKED]}
      | {2{t.kind == FRM_BEACON && r[CTL_SUPERVISOR]}}
      | {nc && t.src_port == PORT2_ID, nc && t.src_port == PORT1_ID};
  endfunction

  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 40747;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped word
    foreach (rl[k]) begin
      apb(1'b0, ADDR_RELOAD_LOW + 12'(4 * k * 2), 32'h0);
      chk(q, 32'h0);
    end
    apb(1'b1, 12'h1B4, 32'hFFFF);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h1B4, 32'h0);
    chk({q[30:0], e}, 32'h1);
    // Two coherent stamps; writes to the counter are ignored
    read_ts(ts0, t0);
    apb(1'b1, ADDR_TS_LOW, 32'hFFFF);
    repeat (1000) @(posedge mclk_i);
    read_ts(ts1, t1);
    chk_near(ts1 - ts0, 32'((t1 - t0) * 2 / 5));
    // Random control settings with frames and host transmits
    for (int i = 0; i < 40; i++) begin
      w = $random(seed);
      w[CTL_PIT_ENABLE] = 1'b0;
      if (i < 8) w[5:1] = {3'b111, i[0], 1'b1};
      apb(1'b1, ADDR_CONTROL, w);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      c = w[15:0] & CTL_STORE_MASK;
      chk(q, {16'h0, c});
      for (int p = 0; p < 2; p++) begin
        f = rrt_rx_frame_t'(9'($random(seed)));
        f.kind = rrt_frame_kind_t'(3'($unsigned($random(seed)) % 5));
        if (f.kind != FRM_OTHER) f.dst_reserved = 1'b0;
        i_rrt_ring_nbr.send(p, f);
        // Verdict looked at mid-cycle, away from the edge that launches it
        @(negedge mclk_i);
        x = exp_fwd(c, p, f);
        chk({31'h0, fwd_valid[p]}, 32'h1);
        chk({31'h0, x[3] & fwd_host[p]}, {31'h0, x[3] & x[1]});
        chk({31'h0, x[2] & fwd_other[p]}, {31'h0, x[2] & x[0]});
      end
      @(posedge mclk_i);
      htx_valid <= 1'b1;
      htx.kind <= rrt_frame_kind_t'(3'(i % 5));
      htx.src_port <= w[0] ? PORT2_ID : PORT1_ID;
      @(posedge mclk_i);
      htx_valid <= 1'b0;
      @(negedge mclk_i);
      chk({30'h0, htx_permit}, {30'h0, exp_tx(c, htx)});
    end
    // Interval timer: shortest reload, then others
    rl = '{32'h1, 32'h3, 32'(4 + $unsigned($random(seed)) % 6)};
    pit_mask <= 1'b1;
    foreach (rl[k]) begin
      apb(1'b1, ADDR_RELOAD_LOW, rl[k]);
      apb(1'b1, ADDR_RELOAD_HIGH, 32'h0);
      apb(1'b0, ADDR_RELOAD_LOW, 32'h0);
      chk(q, rl[k]);
      apb(1'b1, ADDR_CONTROL, 32'h0800);
      pit_period(n);
      pit_period(n);
      chk(32'(n), 32'(5 * rl[k]));
      apb(1'b1, ADDR_CONTROL, 32'h0);
      repeat (4) @(posedge mclk_i);
      pit_clear <= 1'b1;
      @(posedge mclk_i);
      pit_clear <= 1'b0;
      repeat (60) @(posedge mclk_i);
      chk({31'h0, pit_flag}, 32'h0);
    end
    // Beacon timeouts: port 1 alone enabled, 8 ticks make 40 cycles
    apb(1'b1, ADDR_CONTROL, 32'h0202);
    t0 = 0;
    t1 = 0;
    repeat (180) begin
      @(posedge mclk_i);
      t0 += bto[0];
      t1 += bto[1];
    end
    chk(32'(t0), 32'h4);
    chk(32'(t1), 32'h0);
    conclude();
  end
endmodule
